/* File: hw/ofr_pkg.sv */
// Package of constants and types for the overcurrent fault-response controller
package ofr_pkg;

  // ---------------------------------------------------------------
  // Clock rate
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;

  // ---------------------------------------------------------------
  // Timing figures in their own units and derived cycle counts
  // ---------------------------------------------------------------
  localparam int unsigned BLANK_MS = 21;          // Overcurrent blank interval
  localparam int unsigned RETRY_MS = 620;         // Autoretry off interval
  localparam int unsigned DEBOUNCE_US = 1000;     // Input debounce interval
  localparam int unsigned BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);

  // ---------------------------------------------------------------
  // Limit-type encoding and reset value
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OFR_LATCH,
    OFR_RETRY,
    OFR_CONT
  } ofr_type_e;

  localparam ofr_type_e TYPE_RESET = OFR_CONT;    // Power-up default type

  // ---------------------------------------------------------------
  // Width of the interval counters
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W = 32;

endpackage

/* File: hw/ofr_interval_timer.sv */
// Restartable interval counter that reports when a run has lasted its full length
`timescale 1ns/1ps

module ofr_interval_timer #(
  parameter int unsigned LENGTH = 4,
  parameter int unsigned CNT_W = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  // Status
  output logic done
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (LENGTH < 1 || CNT_W < 2 || LENGTH >= (64'h1 << CNT_W) - 1) begin : g_bad_len
    $error("ofr_interval_timer: LENGTH does not fit the counter");
  end

  logic [CNT_W-1:0] count; // Cycles spent running so far

  // Count while running, restart from zero when run falls, hold at the end
  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      count <= '0;
    end else if (count != LENGTH[CNT_W-1:0]) begin
      count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Done once the full length has elapsed while still running
  assign done = run && (count == LENGTH[CNT_W-1:0]);

endmodule

/* File: hw/ofr_ctrl.sv */
// Fault-response controller deciding switch gate enable and fault indicator
// Contract
// - Flag overcurrent only after full blank interval.
// - Overcurrent clearing early restarts the blank timer.
// - Latch type: blank expiry turns switch off until released.
// - Enable toggle or power cycle releases latch.
// - Continuous type keeps switch on, limits current.
// - Continuous flag follows blanked overcurrent, clears promptly.
// - Reverse current trips switch unless reverse flow allowed.
// - Fault indicator low on any listed fault; undervoltage turns the switch off without asserting the indicator.
// - Over-temperature turns switch off, asserts flag.
// - Thermal clear resumes, except latch type stays off.
// - Autoretry waits retry interval after thermal clear.
// - Continuous thermal trip disables only while hot.
// - Thermal trip acts with no blanking.
// - Low select pin chooses internal preset threshold.
// - Switch off only for enable_n high, enable low.
// - Switch on after input above undervoltage debounced.
// - Grounded limit-set resistor asserts fault indicator.
// - Decode limit type from the two selects.
// - Sample policy chooses continuous or low-drop sampling.
// - Autoretry: blank expiry, off retry, on, repeat.
// - Overvoltage or undervoltage turns switch off.
`timescale 1ns/1ps

module ofr_ctrl #(
  parameter int unsigned BLANK_CYCLES = ofr_pkg::BLANK_CYC,
  parameter int unsigned RETRY_CYCLES = ofr_pkg::RETRY_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = ofr_pkg::DEBOUNCE_CYC
) (
  // Clock and reset (reset models the input supply power cycle)
  input wire logic ref_clk,
  input wire logic reset,
  // Enable pins
  input wire logic enable,
  input wire logic high_voltage_enable_n,
  // Limit-type selection pins
  input wire logic limit_type_select_lo,
  input wire logic limit_type_select_hi,
  input wire logic type_sample_policy,
  input wire logic reverse_flow_allow,
  // Comparator outputs
  input wire logic overcurrent,
  input wire logic over_temperature,
  input wire logic reverse_current,
  input wire logic limit_set_shorted,
  input wire logic drop_below_threshold,
  input wire logic overvoltage_lockout_pin_selected,
  input wire logic overvoltage_lockout_external_trip,
  input wire logic overvoltage_lockout_internal_trip,
  input wire logic undervoltage_lockout_pin_selected,
  input wire logic undervoltage_lockout_external_trip,
  input wire logic undervoltage_lockout_internal_trip,
  // Switch drive
  output logic switch_on,
  output logic current_limit_active,
  // Open-drain fault indicator, pulled low while enabled
  output logic fault_indicator_n,
  output logic fault_indicator_oe,
  // Status
  output logic latched_off,
  output logic [1:0] limit_type
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (BLANK_CYCLES < 1 || RETRY_CYCLES < 1 || DEBOUNCE_CYCLES < 1) begin : g_bad_time
    $error("ofr_ctrl: interval counts must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned NSYNC = 16;

  logic [NSYNC-1:0] raw_in; // Asynchronous pin and comparator levels
  logic [NSYNC-1:0] sync_a; // First synchroniser stage
  logic [NSYNC-1:0] sync_b; // Second stage, safe to use

  assign raw_in = {enable, high_voltage_enable_n, limit_type_select_lo, limit_type_select_hi,
                   type_sample_policy, reverse_flow_allow, overcurrent, over_temperature,
                   reverse_current, limit_set_shorted, drop_below_threshold, overvoltage_lockout_pin_selected,
                   overvoltage_lockout_external_trip, overvoltage_lockout_internal_trip, undervoltage_lockout_pin_selected, undervoltage_lockout_external_trip};

  // Two flip-flops per input, one generate slice each
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
      end else begin
        sync_a[i] <= raw_in[i];
        sync_b[i] <= sync_a[i];
      end
    end
  end

  // Two extra flops for the one input outside the packed vector
  logic undervoltage_lockout_int_a; // First stage of internal undervoltage trip
  logic undervoltage_lockout_int_s; // Synchronised internal undervoltage trip

  // Synchronise the internal undervoltage comparator
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      undervoltage_lockout_int_a <= 1'b0;
      undervoltage_lockout_int_s <= 1'b0;
    end else begin
      undervoltage_lockout_int_a <= undervoltage_lockout_internal_trip;
      undervoltage_lockout_int_s <= undervoltage_lockout_int_a;
    end
  end

  // Named views of the synchronised inputs
  logic en_s, high_voltage_enable_n_n_s, sel_lo_s, sel_hi_s, policy_s, rev_allow_s;
  logic oc_s, ot_s, rc_s, short_s, drop_s, ov_sel_s, ov_ext_s, ov_int_s, uv_sel_s, uv_ext_s;

  assign {en_s, high_voltage_enable_n_n_s, sel_lo_s, sel_hi_s, policy_s, rev_allow_s, oc_s, ot_s,
          rc_s, short_s, drop_s, ov_sel_s, ov_ext_s, ov_int_s, uv_sel_s, uv_ext_s} = sync_b;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------

  // Limit-type decode from the select pair
  function automatic ofr_pkg::ofr_type_e decode_type(input logic hi, input logic lo);
    if (hi) begin
      decode_type = ofr_pkg::OFR_CONT;
    end else if (lo) begin
      decode_type = ofr_pkg::OFR_RETRY;
    end else begin
      decode_type = ofr_pkg::OFR_LATCH;
    end
  endfunction

  // Pick internal preset result when the pin sits below its select level
  function automatic logic pick_trip(input logic pin_selected, input logic ext, input logic intl);
    pick_trip = pin_selected ? ext : intl;
  endfunction

  // ---------------------------------------------------------------
  // Supply and enable conditions
  // ---------------------------------------------------------------
  logic ov_trip; // Overvoltage lockout in effect
  logic uv_trip; // Undervoltage lockout in effect
  logic enabled; // Enable truth table says on
  logic enabled_d; // Enabled one cycle ago
  logic en_seen_off; // An off phase of the enables has been seen
  logic en_release; // Enable off then on again

  assign ov_trip = pick_trip(ov_sel_s, ov_ext_s, ov_int_s);
  assign uv_trip = pick_trip(uv_sel_s, uv_ext_s, undervoltage_lockout_int_s);
  assign enabled = !(high_voltage_enable_n_n_s && !en_s);

  // Track enable history for release detection
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enabled_d <= 1'b0;
      en_seen_off <= 1'b0;
    end else begin
      enabled_d <= enabled;
      if (!enabled) begin
        en_seen_off <= 1'b1;
      end else if (en_release) begin
        en_seen_off <= 1'b0;
      end
    end
  end

  // Release on the return to on after an off phase
  assign en_release = enabled && !enabled_d && en_seen_off;

  // ---------------------------------------------------------------
  // Limit-type sampling
  // ---------------------------------------------------------------
  ofr_pkg::ofr_type_e cur_type; // Limit type in force

  // Sample continuously or only at low drop, default continuous
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cur_type <= ofr_pkg::TYPE_RESET;
    end else if (policy_s || drop_s) begin
      cur_type <= decode_type(sel_hi_s, sel_lo_s);
    end
  end

  assign limit_type = cur_type;

  // ---------------------------------------------------------------
  // Input debounce
  // ---------------------------------------------------------------
  logic supply_ok; // Input above undervoltage long enough

  ofr_interval_timer #(
    .LENGTH(DEBOUNCE_CYCLES),
    .CNT_W(ofr_pkg::CNT_W)
  ) u_debounce (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(!uv_trip),
    .done(supply_ok)
  );

  // ---------------------------------------------------------------
  // Blank interval
  // ---------------------------------------------------------------
  logic retry_off; // Autoretry off phase active
  logic blank_run; // Overcurrent present while the switch conducts
  logic blank_done; // Overcurrent has lasted the full blank interval

  assign blank_run = oc_s && switch_on && !en_release;

  ofr_interval_timer #(
    .LENGTH(BLANK_CYCLES),
    .CNT_W(ofr_pkg::CNT_W)
  ) u_blank (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(blank_run),
    .done(blank_done)
  );

  // ---------------------------------------------------------------
  // Latched shutdown
  // ---------------------------------------------------------------
  logic latch; // Switch held off until released

  // Latch on blank expiry or thermal trip in latch type
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latch <= 1'b0;
    end else if (cur_type == ofr_pkg::OFR_LATCH && (blank_done || ot_s)) begin
      latch <= 1'b1;
    end else if (en_release) begin
      latch <= 1'b0;
    end
  end

  assign latched_off = latch;

  // ---------------------------------------------------------------
  // Autoretry sequencing
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OFR_RUN,
    OFR_HOT,
    OFR_WAIT
  } ofr_retry_e;

  ofr_retry_e retry_state; // Autoretry state
  ofr_retry_e next_retry_state;
  logic retry_done; // Retry interval has elapsed
  logic retry_flag; // Fault indicator held through retry cycles
  logic [1:0] switch_hist; // Switch state one and two cycles back; the comparator lags the gate

  assign retry_off = (retry_state != OFR_RUN);

  ofr_interval_timer #(
    .LENGTH(RETRY_CYCLES),
    .CNT_W(ofr_pkg::CNT_W)
  ) u_retry (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(retry_state == OFR_WAIT),
    .done(retry_done)
  );

  // Next autoretry state
  always_comb begin
    next_retry_state = retry_state;
    case (retry_state)
      OFR_RUN: begin
        if (cur_type == ofr_pkg::OFR_RETRY && ot_s) begin
          next_retry_state = OFR_HOT;
        end else if (cur_type == ofr_pkg::OFR_RETRY && blank_done) begin
          next_retry_state = OFR_WAIT;
        end
      end
      OFR_HOT: begin
        if (!ot_s) begin
          next_retry_state = OFR_WAIT;
        end
      end
      OFR_WAIT: begin
        if (ot_s) begin
          next_retry_state = OFR_HOT;
        end else if (retry_done) begin
          next_retry_state = OFR_RUN;
        end
      end
      default: begin
        next_retry_state = OFR_RUN;
      end
    endcase
    if (en_release || cur_type != ofr_pkg::OFR_RETRY) begin
      next_retry_state = OFR_RUN;
    end
  end

  // Autoretry state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      retry_state <= OFR_RUN;
    end else begin
      retry_state <= next_retry_state;
    end
  end

  // Keep the fault indicator low across retries while the fault persists
  always_ff @(posedge ref_clk) begin
    if (reset || en_release || cur_type != ofr_pkg::OFR_RETRY) begin
      retry_flag <= 1'b0;
    end else if (blank_done) begin
      retry_flag <= 1'b1;
    end else if (retry_state == OFR_RUN && switch_on && (&switch_hist) && !oc_s) begin
      retry_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Switch and fault indicator
  // ---------------------------------------------------------------
  logic rev_trip; // Reverse current trips the switch
  logic next_switch_on;
  logic next_fault;

  assign rev_trip = rc_s && !rev_allow_s;

  // Gate decision from all conditions
  always_comb begin
    next_switch_on = enabled && supply_ok && !ov_trip && !uv_trip;
    if (rev_trip || ot_s || short_s || latch || retry_off) begin
      next_switch_on = 1'b0;
    end
    if (cur_type == ofr_pkg::OFR_LATCH && blank_done) begin
      next_switch_on = 1'b0;
    end
    if (cur_type == ofr_pkg::OFR_RETRY && blank_done) begin
      next_switch_on = 1'b0;
    end
  end

  // Fault indicator sources
  always_comb begin
    next_fault = blank_done || rev_trip || ot_s || short_s || ov_trip;
    if (retry_flag || latch) begin
      next_fault = 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      switch_on <= 1'b0;
      fault_indicator_oe <= 1'b0;
      current_limit_active <= 1'b0;
      switch_hist <= 2'h0;
    end else begin
      switch_on <= next_switch_on;
      switch_hist <= {switch_hist[0], switch_on};
      fault_indicator_oe <= next_fault;
      current_limit_active <= next_switch_on && oc_s;
    end
  end

  // Open-drain: drive low only when enabled
  assign fault_indicator_n = 1'b0;

endmodule

/* File: tb/ofr_ctrl_assertions.sv */
// Port-level timing checker for the fault-response controller
`timescale 1ns/1ps

module ofr_ctrl_assertions #(
  parameter int unsigned BLANK_CYCLES = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Pins and comparators
  input wire logic enable,
  input wire logic high_voltage_enable_n,
  input wire logic limit_type_select_lo,
  input wire logic limit_type_select_hi,
  input wire logic type_sample_policy,
  input wire logic reverse_flow_allow,
  input wire logic overcurrent,
  input wire logic over_temperature,
  input wire logic reverse_current,
  input wire logic limit_set_shorted,
  input wire logic overvoltage_lockout_pin_selected,
  input wire logic overvoltage_lockout_external_trip,
  input wire logic overvoltage_lockout_internal_trip,
  input wire logic undervoltage_lockout_pin_selected,
  input wire logic undervoltage_lockout_external_trip,
  input wire logic undervoltage_lockout_internal_trip,
  // Outputs
  input wire logic switch_on,
  input wire logic current_limit_active,
  input wire logic fault_indicator_n,
  input wire logic fault_indicator_oe,
  input wire logic latched_off,
  input wire logic [1:0] limit_type
);
  // ---------------------------------------------------------------
  // Run length of overcurrent while the switch conducts
  // ---------------------------------------------------------------
  logic [31:0] oc_run;
  always_ff @(posedge ref_clk) begin
    if (reset || !(overcurrent && switch_on)) begin
      oc_run <= 32'h0000_0000;
    end else if (oc_run != 32'hFFFF_FFFF) begin
      oc_run <= oc_run + 32'h0000_0001;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // Properties (three edges of input-to-output latency)
  // ---------------------------------------------------------------
  chk_pin_data_low: assert property (fault_indicator_n == 1'b0)
    else $error("fault pin data not low");
  chk_hot_switch_off: assert property (over_temperature [*4] |-> !switch_on && fault_indicator_oe)
    else $error("switch on while hot");
  chk_enable_off: assert property ((high_voltage_enable_n && !enable) [*4] |-> !switch_on)
    else $error("switch on with enables off");
  chk_overvoltage_lockout_ext_trip: assert property (
    (overvoltage_lockout_pin_selected && overvoltage_lockout_external_trip) [*4] |-> !switch_on && fault_indicator_oe)
    else $error("external overvoltage ignored");
  chk_overvoltage_lockout_int_trip: assert property (
    (!overvoltage_lockout_pin_selected && overvoltage_lockout_internal_trip) [*4] |-> !switch_on && fault_indicator_oe)
    else $error("internal overvoltage ignored");
  chk_undervoltage_lockout_trip_off: assert property (
    (undervoltage_lockout_pin_selected ? undervoltage_lockout_external_trip : undervoltage_lockout_internal_trip) [*4] |-> !switch_on)
    else $error("switch on in undervoltage");
  chk_type_decode: assert property (
    (type_sample_policy && $stable({limit_type_select_hi, limit_type_select_lo})) [*4]
    |-> limit_type == (limit_type_select_hi ? 2'h2 : {1'b0, limit_type_select_lo}))
    else $error("limit type decode wrong");
  chk_latch_after_blank: assert property (
    $rose(latched_off) |-> oc_run >= BLANK_CYCLES || $past(over_temperature, 3))
    else $error("latched before blank interval");
  chk_latch_holds_off: assert property (latched_off |-> !switch_on)
    else $error("switch on while latched");
  chk_limit_needs_on: assert property (current_limit_active |-> switch_on)
    else $error("limiting with switch off");
  chk_reverse_trip: assert property (
    (reverse_current && !reverse_flow_allow) [*4] |-> !switch_on && fault_indicator_oe)
    else $error("reverse current not blocked");
  chk_short_set_flag: assert property (limit_set_shorted [*4] |-> fault_indicator_oe)
    else $error("shorted limit resistor not flagged");
endmodule

bind ofr_ctrl ofr_ctrl_assertions #(.BLANK_CYCLES(BLANK_CYCLES)) ofr_ctrl_assertions_inst (
  .ref_clk(ref_clk), .reset(reset), .enable(enable), .high_voltage_enable_n(high_voltage_enable_n),
  .limit_type_select_lo(limit_type_select_lo), .limit_type_select_hi(limit_type_select_hi),
  .type_sample_policy(type_sample_policy), .reverse_flow_allow(reverse_flow_allow), .overcurrent(overcurrent),
  .over_temperature(over_temperature), .reverse_current(reverse_current), .limit_set_shorted(limit_set_shorted),
  .overvoltage_lockout_pin_selected(overvoltage_lockout_pin_selected), .overvoltage_lockout_external_trip(overvoltage_lockout_external_trip),
  .overvoltage_lockout_internal_trip(overvoltage_lockout_internal_trip), .undervoltage_lockout_pin_selected(undervoltage_lockout_pin_selected),
  .undervoltage_lockout_external_trip(undervoltage_lockout_external_trip), .undervoltage_lockout_internal_trip(undervoltage_lockout_internal_trip), .switch_on(switch_on),
  .current_limit_active(current_limit_active), .fault_indicator_n(fault_indicator_n),
  .fault_indicator_oe(fault_indicator_oe), .latched_off(latched_off), .limit_type(limit_type)
);

/* File: tb/ofr_load_model.sv */
// Load and comparator model on the far side of the switch
`timescale 1ns/1ps

module ofr_load_model (
  // Switch state and requested conditions
  input wire logic switch_on,
  input wire logic short_req,
  input wire logic low_drop_req,
  // Comparator outputs
  output logic overcurrent,
  output logic drop_below_threshold
);
  // A short only draws current while the switch conducts
  assign overcurrent = short_req && switch_on;
  // A limiting switch shows a large drop across it
  assign drop_below_threshold = low_drop_req && !overcurrent;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the fault-response controller
`timescale 1ns/1ps

module testbench;
  // Shortened intervals
  localparam int unsigned BLANK = 20;
  localparam int unsigned RETRY = 50;
  localparam int unsigned DEB = 10;
  // Stimulus
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic enable = 1'b1;
  logic high_voltage_enable_n = 1'b0;
  logic limit_type_select_lo = 1'b0;
  logic limit_type_select_hi = 1'b0;
  logic type_sample_policy = 1'b1;
  logic reverse_flow_allow = 1'b0;
  logic over_temperature = 1'b0;
  logic reverse_current = 1'b0;
  logic limit_set_shorted = 1'b0;
  logic overvoltage_lockout_pin_selected = 1'b0;
  logic overvoltage_lockout_external_trip = 1'b0;
  logic overvoltage_lockout_internal_trip = 1'b0;
  logic undervoltage_lockout_pin_selected = 1'b0;
  logic undervoltage_lockout_external_trip = 1'b0;
  logic undervoltage_lockout_internal_trip = 1'b1;
  logic short_req = 1'b0;
  logic low_drop_req = 1'b1;
  // Observed
  logic overcurrent, drop_below_threshold, switch_on, current_limit_active;
  logic fault_indicator_n, fault_indicator_oe, latched_off;
  logic [1:0] limit_type;
  int mismatches = 0;
  int n_checks = 0;

  always #25 ref_clk = ~ref_clk;

  ofr_load_model ofr_load_model_inst (.switch_on(switch_on), .short_req(short_req), .low_drop_req(low_drop_req),
    .overcurrent(overcurrent), .drop_below_threshold(drop_below_threshold));

  ofr_ctrl #(.BLANK_CYCLES(BLANK), .RETRY_CYCLES(RETRY), .DEBOUNCE_CYCLES(DEB)) ofr_ctrl_inst (
    .ref_clk(ref_clk), .reset(reset), .enable(enable), .high_voltage_enable_n(high_voltage_enable_n),
    .limit_type_select_lo(limit_type_select_lo), .limit_type_select_hi(limit_type_select_hi),
    .type_sample_policy(type_sample_policy), .reverse_flow_allow(reverse_flow_allow), .overcurrent(overcurrent),
    .over_temperature(over_temperature), .reverse_current(reverse_current), .limit_set_shorted(limit_set_shorted),
    .drop_below_threshold(drop_below_threshold), .overvoltage_lockout_pin_selected(overvoltage_lockout_pin_selected),
    .overvoltage_lockout_external_trip(overvoltage_lockout_external_trip), .overvoltage_lockout_internal_trip(overvoltage_lockout_internal_trip),
    .undervoltage_lockout_pin_selected(undervoltage_lockout_pin_selected), .undervoltage_lockout_external_trip(undervoltage_lockout_external_trip),
    .undervoltage_lockout_internal_trip(undervoltage_lockout_internal_trip), .switch_on(switch_on), .current_limit_active(current_limit_active),
    .fault_indicator_n(fault_indicator_n), .fault_indicator_oe(fault_indicator_oe), .latched_off(latched_off),
    .limit_type(limit_type));

  // Wait n edges, then step just past the edge
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask

  // Compare and count
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Switch state and fault pin together
  task automatic st(input logic on, input logic flt);
    chk(switch_on, on);
    chk(fault_indicator_oe, flt);
  endtask

  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(5000 * 50);
    mismatches++;
    final_report();
  end

  initial begin
    w(10);
    chk(limit_type, 2'h2);
    reset = 1'b0;
    // Debounce restarts on a dip of the supply
    w(3);
    undervoltage_lockout_internal_trip = 1'b0;
    w(6);
    undervoltage_lockout_internal_trip = 1'b1;
    w(1);
    undervoltage_lockout_internal_trip = 1'b0;
    w(9);
    st(1'b0, 1'b0);
    chk(limit_type, 2'h0);
    w(8);
    st(1'b1, 1'b0);
    // Enable truth table
    for (int i = 0; i < 4; i++) begin
      {high_voltage_enable_n, enable} = i[1:0];
      w(5);
      st(i != 2, 1'b0);
    end
    // Latch type: short overload restarts blanking, then latches
    short_req = 1'b1;
    w(12);
    short_req = 1'b0;
    w(5);
    short_req = 1'b1;
    w(BLANK - 4);
    st(1'b1, 1'b0);
    w(10);
    st(1'b0, 1'b1);
    short_req = 1'b0;
    w(100);
    st(1'b0, 1'b1);
    chk(latched_off, 1'b1);
    enable = 1'b0;
    w(5);
    enable = 1'b1;
    w(5);
    st(1'b1, 1'b0);
    chk(latched_off, 1'b0);
    // Power cycle release
    short_req = 1'b1;
    w(BLANK + 8);
    chk(latched_off, 1'b1);
    short_req = 1'b0;
    reset = 1'b1;
    w(2);
    chk(latched_off, 1'b0);
    reset = 1'b0;
    w(DEB + 8);
    st(1'b1, 1'b0);
    // Autoretry
    limit_type_select_lo = 1'b1;
    w(5);
    chk(limit_type, 2'h1);
    short_req = 1'b1;
    w(BLANK + 10);
    w(RETRY - 20);
    st(1'b0, 1'b1);
    // Fault persists into the next on phase: indicator stays low
    w(22);
    st(1'b1, 1'b1);
    short_req = 1'b0;
    w(8);
    st(1'b1, 1'b0);
    over_temperature = 1'b1;
    w(5);
    st(1'b0, 1'b1);
    over_temperature = 1'b0;
    w(20);
    chk(switch_on, 1'b0);
    w(RETRY);
    chk(switch_on, 1'b1);
    // Continuous
    limit_type_select_hi = 1'b1;
    w(5);
    chk(limit_type, 2'h2);
    short_req = 1'b1;
    w(8);
    st(1'b1, 1'b0);
    chk(current_limit_active, 1'b1);
    w(BLANK);
    st(1'b1, 1'b1);
    short_req = 1'b0;
    w(5);
    st(1'b1, 1'b0);
    over_temperature = 1'b1;
    w(30);
    st(1'b0, 1'b1);
    over_temperature = 1'b0;
    w(5);
    st(1'b1, 1'b0);
    // Reverse current
    reverse_current = 1'b1;
    w(5);
    st(1'b0, 1'b1);
    reverse_flow_allow = 1'b1;
    w(5);
    st(1'b1, 1'b0);
    reverse_current = 1'b0;
    reverse_flow_allow = 1'b0;
    limit_set_shorted = 1'b1;
    w(5);
    chk(fault_indicator_oe, 1'b1);
    limit_set_shorted = 1'b0;
    // Overvoltage threshold selection
    for (int i = 0; i < 4; i++) begin
      {overvoltage_lockout_pin_selected, overvoltage_lockout_external_trip} = i[1:0];
      overvoltage_lockout_internal_trip = !i[0];
      w(5);
      st(i == 1 || i == 2, i == 0 || i == 3);
    end
    overvoltage_lockout_external_trip = 1'b0;
    undervoltage_lockout_pin_selected = 1'b1;
    undervoltage_lockout_internal_trip = 1'b1;
    w(5);
    chk(switch_on, 1'b1);
    undervoltage_lockout_external_trip = 1'b1;
    w(5);
    chk(switch_on, 1'b0);
    // Sampling only at low drop
    type_sample_policy = 1'b0;
    low_drop_req = 1'b0;
    limit_type_select_hi = 1'b0;
    limit_type_select_lo = 1'b0;
    w(6);
    chk(limit_type, 2'h2);
    low_drop_req = 1'b1;
    w(6);
    chk(limit_type, 2'h0);
    // Latch type: thermal trip stays latched after cooling
    undervoltage_lockout_external_trip = 1'b0;
    w(DEB + 8);
    st(1'b1, 1'b0);
    over_temperature = 1'b1;
    w(5);
    st(1'b0, 1'b1);
    over_temperature = 1'b0;
    w(20);
    st(1'b0, 1'b1);
    chk(latched_off, 1'b1);
    final_report();
  end
endmodule
